//--- common/mpl_pkg.sv
// Purpose: Shared constants and types for the panel meter level control.
// Assumes: 20 MHz hclk, AHB-Lite register access with 32-bit words.
// Notes: Levels, display selections and register map live here.
package mpl_pkg;
  // Clock and key hold timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLEAR_HOLD_MS = 1000;
  localparam int CLEAR_HOLD_CYC = (CLEAR_HOLD_MS * 1000000) / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_SCALE_IN = 8'h08;
  localparam logic [7:0] OFS_SCALE_DISP = 8'h0c;
  localparam logic [7:0] OFS_SV1 = 8'h10;
  localparam logic [7:0] OFS_SV2 = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1c;
  localparam logic [7:0] OFS_DISPLAY = 8'h20;
  localparam logic [7:0] OFS_PRESCALE = 8'h24;
  localparam logic [7:0] OFS_MAXV = 8'h28;
  localparam logic [7:0] OFS_MINV = 8'h2c;
  // Config field positions
  localparam int CFG_OPL_LSB = 0;
  localparam int CFG_LVL_LSB = 2;
  localparam int CFG_EDL_BIT = 4;
  localparam int CFG_FRQ_BIT = 5;
  localparam int CFG_DP_LSB = 6;
  localparam int CFG_CMP_BIT = 9;
  // Status bit positions
  localparam int ST_OVER = 0;
  localparam int ST_UNDER = 1;
  localparam int ST_MMCLR = 2;
  localparam int ST_LVLREF = 3;
  localparam int ST_RANGE = 4;
  localparam int ST_W = 5;
  // Display limits and value ranges
  localparam logic signed [17:0] DISP_HI = 18'sd99999;
  localparam logic signed [17:0] DISP_LO = -18'sd19999;
  localparam logic [16:0] VAL_MAX = 17'd99999;
  // Reset and default values
  localparam logic [1:0] OPL_RST = 2'h0;
  localparam logic [1:0] LVL_LOCK_RST = 2'h0;
  localparam logic [2:0] DP_DEF_30HZ = 3'h2; // Two decimals
  localparam logic [2:0] DP_DEF_5KHZ = 3'h0; // No decimal point
  localparam logic [16:0] SCALE_IN_DEF = 17'd1;
  localparam logic signed [17:0] SCALE_DISP_DEF = 18'sd1;
  localparam int FRAC_BITS = 16;
  localparam int DIV_STEPS = 34;
  // Setting levels
  typedef enum logic [1:0] {
    LV_PROTECT, LV_OPERATION, LV_INITIAL, LV_ADVANCED
  } mpl_level_e;
  // Run-mode display selection
  typedef enum logic [2:0] {
    DS_MEAS, DS_MAX, DS_MIN, DS_SV1, DS_SV2
  } mpl_disp_e;
endpackage

//--- src/mpl_top.sv
// Purpose: Front-panel level control, lockouts and scaling of a pulse meter.
// Assumes: Keys and measured frequency are synchronous to hclk.
// Notes: Registers on AHB-Lite, zero wait states, always OKAY.
// Summary of operation
// - Peak key from measurement shows max/min
// - Hold peak key one second clears max/min
// - Mode key steps to output one, two values
// - Set values key-editable only while edits unlocked; bus writes anytime except in a cycle with an up-key edit
// - Measurement runs only in protect/operation levels
// - Range change restores dependent parameter defaults
// - Operation lockout two hides set values
// - No operation lockout without comparator outputs
// - Level lockout gates initial and advanced levels
// - Edit lockout blocks key setting changes
// - Protect parameters always stay changeable
// - Frequency range is 30 Hz or 5 kHz
// - Display equals frequency times derived prescale
// - Scaling values accepted as in-range integers
// - Decimal point placed without touching arithmetic
// - Above limit shows upper limit flashing
// - Below limit shows lower limit flashing
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module mpl_top
  import mpl_pkg::*;
#(
  parameter int HOLD_CYCLES = CLEAR_HOLD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic peak_key,
  input wire logic mode_key,
  input wire logic shift_key,
  input wire logic up_key,
  input wire logic level_key,
  input wire logic [16:0] freq_in,
  input wire logic freq_valid,
  output logic [1:0] level_out,
  output logic meas_run,
  output logic [2:0] disp_kind,
  output logic signed [17:0] disp_value,
  output logic disp_flash,
  output logic [2:0] dp_pos,
  output logic freq_range,
  output logic edit_active,
  output logic [2:0] edit_digit
);
  logic [1:0] opl_reg;
  logic [1:0] lvl_lock_reg;
  logic edl_reg;
  logic frq_reg;
  logic cmp_reg;
  logic [16:0] sc_in_reg;
  logic signed [17:0] sc_disp_reg;
  logic [16:0] sv1_reg;
  logic [16:0] sv2_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic [ST_W-1:0] st_set;
  logic st_rd_clr;
  mpl_level_e level_reg;
  mpl_disp_e ds_reg;
  logic [24:0] hold_cnt;
  logic mm_valid;
  logic mm_upd;
  logic signed [17:0] maxv_reg;
  logic signed [17:0] minv_reg;
  logic signed [17:0] scaled_reg;
  logic [33:0] alpha_reg;
  logic alpha_neg;
  logic div_busy;
  logic [5:0] div_cnt;
  logic [33:0] div_q;
  logic [17:0] div_rem;
  logic div_start;
  logic [4:0] key_prev;
  logic peak_p, mode_p, shift_p, up_p, level_p;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic bus_take;
  logic wr_en;
  logic init_lvl;
  logic sv_allowed;
  logic sv_edit_ok;
  logic [1:0] lvl_req;
  logic lvl_req_v;

  // Key press edges; keys are already synchronous
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_prev <= 5'h00;
    end else begin
      key_prev <= {peak_key, mode_key, shift_key, up_key, level_key};
    end
  end
  assign peak_p = peak_key & ~key_prev[4];
  assign mode_p = mode_key & ~key_prev[3];
  assign shift_p = shift_key & ~key_prev[2];
  assign up_p = up_key & ~key_prev[1];
  assign level_p = level_key & ~key_prev[0];

  // Bus address phase capture
  assign bus_take = hsel & htrans[1] & hready;
  assign wr_en = wr_pend;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= bus_take & hwrite;
      wr_addr <= haddr[7:0];
      hreadyout <= 1'b1; // Never stalls
      hresp <= 1'b0;
    end
  end

  assign init_lvl = (level_reg == LV_INITIAL);
  assign sv_allowed = cmp_reg & (opl_reg != 2'h2);
  assign sv_edit_ok = ~edl_reg;

  // Protect-level parameters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opl_reg <= OPL_RST;
      lvl_lock_reg <= LVL_LOCK_RST;
      edl_reg <= 1'b0;
      cmp_reg <= 1'b1;
    end else if (wr_en && wr_addr == OFS_CONFIG) begin
      lvl_lock_reg <= hwdata[CFG_LVL_LSB +: 2];
      edl_reg <= hwdata[CFG_EDL_BIT];
      cmp_reg <= hwdata[CFG_CMP_BIT];
      if (!hwdata[CFG_CMP_BIT]) begin
        opl_reg <= OPL_RST;
      end else if (hwdata[CFG_OPL_LSB +: 2] != 2'h3) begin
        opl_reg <= hwdata[CFG_OPL_LSB +: 2];
      end
    end
  end

  // Initial-level parameters: range, decimal point, scaling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frq_reg <= 1'b0;
      dp_pos <= DP_DEF_30HZ;
      sc_in_reg <= SCALE_IN_DEF;
      sc_disp_reg <= SCALE_DISP_DEF;
    end else if (wr_en && init_lvl) begin
      if (wr_addr == OFS_CONFIG) begin
        // One bit picks 30 Hz or 5 kHz
        frq_reg <= hwdata[CFG_FRQ_BIT];
        if (hwdata[CFG_FRQ_BIT] != frq_reg) begin
          dp_pos <= hwdata[CFG_FRQ_BIT] ? DP_DEF_5KHZ : DP_DEF_30HZ;
          sc_in_reg <= SCALE_IN_DEF;
          sc_disp_reg <= SCALE_DISP_DEF;
        end else if (hwdata[CFG_DP_LSB +: 3] <= 3'h4) begin
          dp_pos <= hwdata[CFG_DP_LSB +: 3];
        end
      end
      if (wr_addr == OFS_SCALE_IN && hwdata[31:17] == 15'h0000 &&
          hwdata[16:0] <= VAL_MAX) begin
        sc_in_reg <= hwdata[16:0];
      end
      if (wr_addr == OFS_SCALE_DISP &&
          $signed(hwdata) <= $signed({{14{1'b0}}, DISP_HI}) &&
          $signed(hwdata) >= $signed({{14{1'b1}}, DISP_LO})) begin
        sc_disp_reg <= hwdata[17:0];
      end
    end
  end
  assign freq_range = frq_reg;

  // Prescale recompute on any scaling or range write
  assign div_start = wr_en && init_lvl && (wr_addr == OFS_SCALE_IN ||
                     wr_addr == OFS_SCALE_DISP || wr_addr == OFS_CONFIG);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_busy <= 1'b0;
      div_cnt <= 6'h00;
      div_q <= 34'h0;
      div_rem <= 18'h0;
      alpha_reg <= {18'h0, 16'h0001} << FRAC_BITS;
      alpha_neg <= 1'b0;
    end else if (div_start) begin
      // Start one cycle late so the stored values are settled
      div_busy <= 1'b1;
      div_cnt <= 6'h00;
      div_rem <= 18'h0;
      div_q <= 34'h0;
    end else if (div_busy) begin
      if (div_cnt == 6'h00 && div_q == 34'h0 && div_rem == 18'h0) begin
        // Dividend is the display magnitude shifted up by the Q16 point
        div_q <= {(sc_disp_reg[17] ? 18'(-sc_disp_reg) :
                   18'(sc_disp_reg)), 16'h0000};
        div_cnt <= 6'h01;
      end else if (div_cnt <= 6'(DIV_STEPS)) begin
        if ({div_rem[16:0], div_q[33]} >= {1'b0, sc_in_reg}) begin
          div_rem <= {div_rem[16:0], div_q[33]} - {1'b0, sc_in_reg};
          div_q <= {div_q[32:0], 1'b1};
        end else begin
          div_rem <= {div_rem[16:0], div_q[33]};
          div_q <= {div_q[32:0], 1'b0};
        end
        div_cnt <= div_cnt + 6'h01;
      end else begin
        div_busy <= 1'b0;
        alpha_reg <= (sc_in_reg == 17'h0) ? 34'h0 : div_q;
        alpha_neg <= sc_disp_reg[17];
      end
    end
  end

  // Scaling of each new sample, clamped to the display limits
  logic [50:0] prod;
  logic [34:0] mag;
  assign prod = {34'h0, freq_in} * {17'h0, alpha_reg};
  assign mag = prod[50:FRAC_BITS];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scaled_reg <= 18'sh0;
      disp_flash <= 1'b0;
    end else if (freq_valid && meas_run) begin
      if (!alpha_neg && mag > 35'(DISP_HI)) begin
        scaled_reg <= DISP_HI;
        disp_flash <= 1'b1;
      end else if (alpha_neg && mag > 35'(-DISP_LO)) begin
        scaled_reg <= DISP_LO;
        disp_flash <= 1'b1;
      end else begin
        scaled_reg <= alpha_neg ? -18'(mag) : 18'(mag);
        disp_flash <= 1'b0;
      end
    end
  end

  // Level requests from bus or level key
  always_comb begin
    lvl_req = 2'(LV_OPERATION);
    lvl_req_v = 1'b0;
    if (wr_en && wr_addr == OFS_LEVEL) begin
      lvl_req = hwdata[1:0];
      lvl_req_v = 1'b1;
    end else if (level_p) begin
      lvl_req = (level_reg == LV_OPERATION) ? 2'(LV_INITIAL) :
                2'(LV_OPERATION);
      lvl_req_v = 1'b1;
    end
  end

  logic lvl_deny;
  assign lvl_deny = (lvl_req == 2'(LV_ADVANCED) && lvl_lock_reg != 2'h0) ||
                    (lvl_req == 2'(LV_INITIAL) && lvl_lock_reg == 2'h2);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_reg <= LV_OPERATION;
      meas_run <= 1'b1;
    end else begin
      if (lvl_req_v && !lvl_deny) begin
        level_reg <= mpl_level_e'(lvl_req);
      end
      meas_run <= !(lvl_req_v && !lvl_deny) ?
                  (level_reg == LV_PROTECT || level_reg == LV_OPERATION) :
                  (lvl_req == 2'(LV_PROTECT) || lvl_req == 2'(LV_OPERATION));
    end
  end
  assign level_out = level_reg;

  // Run-mode display stepping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ds_reg <= DS_MEAS;
    end else if (level_reg != LV_OPERATION) begin
      ds_reg <= DS_MEAS;
    end else begin
      case (ds_reg)
        DS_MEAS: begin
          if (peak_p) ds_reg <= DS_MAX;
          // Mode key to output one value
          else if (mode_p && sv_allowed) ds_reg <= DS_SV1;
        end
        DS_MAX, DS_MIN: begin
          if (peak_p) ds_reg <= (ds_reg == DS_MAX) ? DS_MIN : DS_MEAS;
          else if (mode_p && sv_allowed) ds_reg <= DS_SV1;
        end
        DS_SV1: begin
          if (!sv_allowed) ds_reg <= DS_MEAS;
          else if (mode_p) ds_reg <= DS_SV2;
        end
        DS_SV2: begin
          if (!sv_allowed || mode_p) ds_reg <= DS_MEAS;
        end
        default: ds_reg <= DS_MEAS;
      endcase
    end
  end

  logic mm_clear;
  assign mm_clear = (ds_reg == DS_MAX || ds_reg == DS_MIN) && peak_key &&
                    hold_cnt == 25'(HOLD_CYCLES - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt <= 25'h0;
    end else if (!peak_key || (ds_reg != DS_MAX && ds_reg != DS_MIN)) begin
      hold_cnt <= 25'h0;
    end else if (hold_cnt != 25'(HOLD_CYCLES)) begin
      hold_cnt <= hold_cnt + 25'h1;
    end
  end

  // Max/min tracking one edge after each sample, so the new value counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mm_upd <= 1'b0;
      mm_valid <= 1'b0;
      maxv_reg <= 18'sh0;
      minv_reg <= 18'sh0;
    end else begin
      mm_upd <= freq_valid && meas_run;
      if (mm_clear) begin
        mm_valid <= 1'b0;
        maxv_reg <= 18'sh0;
        minv_reg <= 18'sh0;
      end else if (mm_upd) begin
        mm_valid <= 1'b1;
        if (!mm_valid || scaled_reg > maxv_reg) maxv_reg <= scaled_reg;
        if (!mm_valid || scaled_reg < minv_reg) minv_reg <= scaled_reg;
      end
    end
  end

  // Set values: bus writes anytime except in a cycle with an up-key edit, key edits when unlocked
  function automatic logic [16:0] pow10(input logic [2:0] d);
    case (d)
      3'h0: pow10 = 17'd1;
      3'h1: pow10 = 17'd10;
      3'h2: pow10 = 17'd100;
      3'h3: pow10 = 17'd1000;
      default: pow10 = 17'd10000;
    endcase
  endfunction
  logic [16:0] sv_cur;
  logic [17:0] sv_inc;
  assign sv_cur = (ds_reg == DS_SV2) ? sv2_reg : sv1_reg;
  assign sv_inc = {1'b0, sv_cur} + {1'b0, pow10(edit_digit)};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edit_active <= 1'b0;
      edit_digit <= 3'h0;
      sv1_reg <= 17'h0;
      sv2_reg <= 17'h0;
    end else begin
      if (ds_reg != DS_SV1 && ds_reg != DS_SV2 || mode_p || !sv_edit_ok) begin
        edit_active <= 1'b0;
        edit_digit <= 3'h0;
      end else if (shift_p) begin
        // Entry to change mode needs unlock
        edit_active <= 1'b1;
        if (edit_active)
          edit_digit <= (edit_digit == 3'h4) ? 3'h0 : edit_digit + 3'h1;
      end
      // Up key alters digit while unlocked
      if (edit_active && sv_edit_ok && up_p) begin
        if (ds_reg == DS_SV1)
          sv1_reg <= (sv_inc > {1'b0, VAL_MAX}) ? 17'h0 : sv_inc[16:0];
        if (ds_reg == DS_SV2)
          sv2_reg <= (sv_inc > {1'b0, VAL_MAX}) ? 17'h0 : sv_inc[16:0];
      end else if (wr_en && hwdata[16:0] <= VAL_MAX) begin
        if (wr_addr == OFS_SV1) sv1_reg <= hwdata[16:0];
        if (wr_addr == OFS_SV2) sv2_reg <= hwdata[16:0];
      end
    end
  end

  // Displayed value follows the selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_value <= 18'sh0;
      disp_kind <= 3'(DS_MEAS);
    end else begin
      disp_kind <= ds_reg;
      case (ds_reg)
        DS_MAX: disp_value <= maxv_reg;
        DS_MIN: disp_value <= minv_reg;
        DS_SV1: disp_value <= {1'b0, sv1_reg};
        DS_SV2: disp_value <= {1'b0, sv2_reg};
        default: disp_value <= scaled_reg;
      endcase
    end
  end

  // Sticky events; a read clears, a new set wins over it
  always_comb begin
    st_set = '0;
    st_set[ST_OVER] = freq_valid && meas_run && !alpha_neg &&
                      mag > 35'(DISP_HI);
    st_set[ST_UNDER] = freq_valid && meas_run && alpha_neg &&
                       mag > 35'(-DISP_LO);
    st_set[ST_MMCLR] = mm_clear;
    st_set[ST_LVLREF] = lvl_req_v && lvl_deny;
    st_set[ST_RANGE] = wr_en && init_lvl && wr_addr == OFS_CONFIG &&
                       hwdata[CFG_FRQ_BIT] != frq_reg;
  end
  assign st_rd_clr = bus_take && !hwrite && haddr[7:0] == OFS_STATUS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= '0;
      mask_reg <= '0;
      irq <= 1'b0;
    end else begin
      status_reg <= (st_rd_clr ? '0 : status_reg) | st_set;
      if (wr_en && wr_addr == OFS_MASK) mask_reg <= hwdata[ST_W-1:0];
      irq <= |(((st_rd_clr ? '0 : status_reg) | st_set) & mask_reg);
    end
  end

  // Read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (bus_take && !hwrite) begin
      case (haddr[7:0])
        OFS_CONFIG: hrdata <= {22'h0, cmp_reg, dp_pos, frq_reg, edl_reg,
                               lvl_lock_reg, opl_reg};
        OFS_LEVEL: hrdata <= {30'h0, level_reg};
        OFS_SCALE_IN: hrdata <= {15'h0, sc_in_reg};
        OFS_SCALE_DISP: hrdata <= {{14{sc_disp_reg[17]}}, sc_disp_reg};
        OFS_SV1: hrdata <= {15'h0, sv1_reg};
        OFS_SV2: hrdata <= {15'h0, sv2_reg};
        OFS_STATUS: hrdata <= {27'h0, status_reg};
        OFS_MASK: hrdata <= {27'h0, mask_reg};
        OFS_DISPLAY: hrdata <= {{14{scaled_reg[17]}}, scaled_reg};
        OFS_PRESCALE: hrdata <= {alpha_neg, div_busy, alpha_reg[29:0]};
        OFS_MAXV: hrdata <= {{14{maxv_reg[17]}}, maxv_reg};
        OFS_MINV: hrdata <= {{14{minv_reg[17]}}, minv_reg};
        default: hrdata <= 32'h0;
      endcase
    end
  end
endmodule // mpl_top

//--- verif/mpl_top_sva.sv
// Purpose: Port checker for the panel meter level control.
// Assumes: One hclk domain, hresetn asynchronous and active low.
// Notes: Bound to every mpl_top by the statement after endmodule.
`timescale 1ns/10ps
module mpl_top_sva
  import mpl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic peak_key,
  input wire logic level_key,
  input wire logic [1:0] level_out,
  input wire logic meas_run,
  input wire logic [2:0] disp_kind,
  input wire logic signed [17:0] disp_value,
  input wire logic disp_flash,
  input wire logic [2:0] dp_pos
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Slave never stalls and never errors
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_meas_level: assert property (
    $stable(level_out) |-> meas_run == (level_out < 2'h2))
    else $error("measurement state does not follow level");
  a_level_cause: assert property (
    $changed(level_out) |-> $past(level_key) || $past(level_key, 2)
      || $past(level_key, 3) || $past(hsel && hwrite, 2))
    else $error("level moved without key or write");
  a_flash_limit: assert property (
    disp_flash && $stable(disp_flash) && disp_kind == 3'h0 &&
      $stable(disp_kind)
      |-> disp_value == DISP_HI || disp_value == DISP_LO)
    else $error("flashing value is not a display limit");
  a_value_bound: assert property (
    disp_value >= DISP_LO && disp_value <= DISP_HI)
    else $error("shown value outside display limits");
  a_peak_cause: assert property (
    $past(disp_kind) == 3'h0 && disp_kind == 3'h1
      |-> $past(peak_key, 2) || $past(peak_key, 3))
    else $error("peak display without peak key");
  a_meas_step: assert property (
    $past(disp_kind) == 3'h0 && disp_kind != 3'h0
      |-> disp_kind == 3'h1 || disp_kind == 3'h3)
    else $error("bad step away from measurement");
  a_sv_order: assert property (
    $past(disp_kind) == 3'h3 && disp_kind != 3'h3
      |-> disp_kind == 3'h4 || disp_kind == 3'h0)
    else $error("output one value not followed by output two");
  a_dp_range: assert property (dp_pos <= 3'h4)
    else $error("decimal position out of range");
  // Main scenarios reached
  c_flash: cover property (disp_flash);
  c_init: cover property (level_out == 2'h2 && !meas_run);
  c_sv2: cover property (disp_kind == 3'h4);
endmodule // mpl_top_sva

bind mpl_top mpl_top_sva i_mpl_top_sva (.*);

//--- verif/mpl_panel_model.sv
// Purpose: Operator keys and pulse sensor facing the meter.
// Assumes: Driven right after rising hclk edges.
// Notes: Keys order is peak, mode, shift, up, level.
`timescale 1ns/10ps
module mpl_panel_model (
  input wire logic hclk,
  output logic [4:0] keys,
  output logic [16:0] freq_in,
  output logic freq_valid
);
  // Idle at time zero
  initial begin
    keys = 5'h00;
    freq_in = 17'h00000;
    freq_valid = 1'b0;
  end
  // Hold one key n cycles, then let the panel settle
  task automatic press(input int k, input int n);
    keys[k] <= 1'b1;
    repeat (n) @(posedge hclk);
    keys[k] <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  // One sample; the value is scrambled once not valid
  task automatic sample(input logic [16:0] f);
    freq_in <= f;
    freq_valid <= 1'b1;
    @(posedge hclk);
    freq_valid <= 1'b0;
    freq_in <= ~f;
    repeat (3) @(posedge hclk);
  endtask
endmodule // mpl_panel_model

//--- verif/test_mpl_top.sv
// Purpose: Self-checking bench for the panel meter level control.
// Assumes: Zero wait AHB-Lite slave, clear hold shortened to 20.
// Notes: Scaling values come from an xorshift seeded with 39338.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module test_mpl_top
  import mpl_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [31:0] seed = 32'd39338;
  logic [1:0] htrans = 2'h0, level_out;
  logic [2:0] hsize = 3'h2, disp_kind, dp_pos, edit_digit;
  logic hready, hreadyout, hresp, irq, meas_run, disp_flash;
  logic freq_range, edit_active, freq_valid;
  logic [4:0] keys;
  logic [16:0] freq_in;
  logic signed [17:0] disp_value;
  int fail_count = 0, checked = 0, i;
  longint a, d, f, m, s;
  assign hready = hreadyout;
  mpl_top #(.HOLD_CYCLES(20)) i_mpl_top (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .peak_key(keys[0]), .mode_key(keys[1]), .shift_key(keys[2]),
    .up_key(keys[3]), .level_key(keys[4]), .freq_in(freq_in),
    .freq_valid(freq_valid), .level_out(level_out), .meas_run(meas_run),
    .disp_kind(disp_kind), .disp_value(disp_value),
    .disp_flash(disp_flash), .dp_pos(dp_pos), .freq_range(freq_range),
    .edit_active(edit_active), .edit_digit(edit_digit));
  mpl_panel_model i_mpl_panel_model (.hclk(hclk), .keys(keys),
    .freq_in(freq_in), .freq_valid(freq_valid));
  // 20 MHz clock
  initial begin
    forever #25 hclk = ~hclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Shown value is the Q16 product, pinned to the display limits
  function automatic longint shown(longint f, longint m);
    longint v;
    v = (f * (m < 0 ? -m : m)) >> 16;
    v = m < 0 ? -v : v;
    return v > 99999 ? 99999 : (v < -19999 ? -19999 : v);
  endfunction
  task automatic wrap_up();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Edges until ready, bounded so a dead slave cannot hang the run
  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad,
    input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    `CHK(rd, e)
  endtask
  // Poll until the prescale divider is idle
  task automatic idle_calc();
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_PRESCALE, 32'h0);
      n++;
    end while (rd[30] !== 1'b0 && n < 60);
    if (n >= 60) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic key(input int k, input int n);
    i_mpl_panel_model.press(k, n);
  endtask
  task automatic settle();
    repeat (2) @(posedge hclk);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK({level_out, meas_run, dp_pos}, 6'h1a)
    rchk(OFS_CONFIG, 32'h280);
    rchk(OFS_PRESCALE, 32'h10000);
    rchk(8'h40, 32'h0);
    bus(1'b1, OFS_MASK, 32'h1f);
    bus(1'b1, OFS_CONFIG, 32'h208);
    key(4, 1);
    `CHK({level_out, irq}, 3'h3)
    rchk(OFS_STATUS, 32'h8);
    settle();
    `CHK(irq, 1'b0)
    bus(1'b1, OFS_CONFIG, 32'h204);
    key(4, 1);
    `CHK({level_out, meas_run}, 3'h4)
    bus(1'b1, OFS_LEVEL, 32'h3);
    rchk(OFS_LEVEL, 32'h2);
    // Two pinned corners, then random in-range scaling
    for (i = 0; i < 5; i++) begin
      a = i < 2 ? 1 : 1 + rnd() % 1000;
      d = i == 0 ? 15000 : (i == 1 ? -10000 : rnd() % (a * 10));
      f = i < 2 ? 10 - 7 * i : rnd() % 5000;
      m = ((d < 0 ? -d : d) << 16) / a;
      bus(1'b1, OFS_SCALE_IN, 32'(a));
      bus(1'b1, OFS_SCALE_DISP, 32'(d));
      idle_calc();
      `CHK(rd, {d < 0, 1'b0, 30'(m)})
      key(4, 1);
      i_mpl_panel_model.sample(17'(f));
      s = shown(f, d < 0 ? -m : m);
      rchk(OFS_DISPLAY, 32'(s));
      `CHK({disp_value, disp_flash}, {18'(s), i < 2})
      key(4, 1);
    end
    bus(1'b1, OFS_SCALE_IN, 32'd100000);
    rchk(OFS_SCALE_IN, 32'(a));
    bus(1'b1, OFS_CONFIG, 32'h2c4);
    idle_calc();
    `CHK({dp_pos, rd}, {3'h3, 1'b0, 1'b0, 30'(m)})
    bus(1'b1, OFS_CONFIG, 32'h224);
    settle();
    `CHK({freq_range, dp_pos}, 4'h8)
    rchk(OFS_SCALE_IN, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[ST_RANGE], 1'b1)
    idle_calc();
    key(4, 1);
    i_mpl_panel_model.sample(17'd500);
    i_mpl_panel_model.sample(17'd300);
    rchk(OFS_MAXV, 32'(DISP_HI));
    key(0, 1);
    `CHK(disp_kind, 3'h1)
    key(0, 30);
    rchk(OFS_MAXV, 32'h0);
    i_mpl_panel_model.sample(17'd500);
    rchk(OFS_MAXV, 32'd500);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[ST_MMCLR], 1'b1)
    key(0, 1);
    key(1, 1);
    `CHK(disp_kind, 3'h3)
    key(2, 1);
    `CHK(edit_active, 1'b1)
    key(2, 1);
    `CHK(edit_digit, 3'h1)
    key(3, 1);
    key(1, 1);
    `CHK(disp_kind, 3'h4)
    key(1, 1);
    `CHK(disp_kind, 3'h0)
    rchk(OFS_SV1, 32'd10);
    bus(1'b1, OFS_CONFIG, 32'h234);
    rchk(OFS_CONFIG, 32'h234);
    key(1, 1);
    key(2, 1);
    `CHK(edit_active, 1'b0)
    key(3, 1);
    key(1, 1);
    key(1, 1);
    rchk(OFS_SV1, 32'd10);
    bus(1'b1, OFS_CONFIG, 32'h236);
    key(1, 1);
    `CHK(disp_kind, 3'h0)
    bus(1'b1, OFS_CONFIG, 32'h036);
    rchk(OFS_CONFIG, 32'h034);
    bus(1'b1, OFS_CONFIG, 32'h030);
    bus(1'b1, OFS_LEVEL, 32'h3);
    settle();
    `CHK({level_out, meas_run}, 3'h6)
    bus(1'b1, OFS_LEVEL, 32'h0);
    settle();
    `CHK({level_out, meas_run}, 3'h1)
    wrap_up();
  end
endmodule // test_mpl_top
